// ===== shared/ppp_defines.svh
// Constants for the parallel port handshake block
// Assumes a 20 MHz core clock; included by design files
`ifndef PPP_DEFINES_SVH
`define PPP_DEFINES_SVH

`define PPP_CLK_NS        50
`define PPP_SETUP_MIN_NS  4300
`define PPP_SETUP_MAX_NS  5300
`define PPP_STROBE_NS     1400
// Setup rounds up from the least time, never past the longest
`define PPP_SETUP_CYC     ((`PPP_SETUP_MIN_NS + `PPP_CLK_NS - 1) / `PPP_CLK_NS)
`define PPP_STROBE_CYC    (`PPP_STROBE_NS / `PPP_CLK_NS)
`define PPP_CNT_W         8
`define PPP_DATA_W        8
`define PPP_SIDE_W        3
`define PPP_DIR_RESET     8'h00
`define PPP_SIDE_RESET    3'h0

`endif

// ===== shared/ppp_pkg.sv
// Types for the parallel port handshake block
// Assumes the defines header is compiled alongside
package ppp_pkg;
  typedef enum logic [4:0] {
    ppp_idle_type_s   = 5'h01,
    ppp_setup_type_s  = 5'h02,
    ppp_strobe_type_s = 5'h04,
    ppp_wait_type_s   = 5'h08,
    ppp_iack_type_s   = 5'h10
  } ppp_state_type;
endpackage

// ===== design/ppp_skid.sv
// Two-entry buffer with valid and ready on both sides
// Assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module ppp_skid #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst,
  // Filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  logic [WIDTH-1:0] mem [2];
  logic             wr_ptr;
  logic             rd_ptr;
  logic [1:0]       count;
  logic             next_wr_ptr;
  logic             next_rd_ptr;
  logic [1:0]       next_count;
  logic             push;
  logic             pop;

  // Handshake terms
  assign in_ready  = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Pointer and fill count next values
  always_comb begin
    next_wr_ptr = push ? ~wr_ptr : wr_ptr;
    next_rd_ptr = pop ? ~rd_ptr : rd_ptr;
    next_count  = count;
    if (push && !pop) begin
      next_count = count + 2'h1;
    end else if (pop && !push) begin
      next_count = count - 2'h1;
    end
  end

  // Register pointers and storage
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count  <= 2'h0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule
`default_nettype wire

// ===== design/ppp_port.sv
// Parallel port handshake engine with per-bit direction control
// Assumes pins are resolved outside; oe low means driving
`include "ppp_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module ppp_port #(
  parameter int SETUP_CYC  = `PPP_SETUP_CYC,
  parameter int STROBE_CYC = `PPP_STROBE_CYC
) (
  // Clock and reset
  input  wire logic                    core_clk,
  input  wire logic                    rst,
  // Host control
  input  wire logic                    input_mode,
  input  wire logic [`PPP_DATA_W-1:0]  data_dir,
  input  wire logic [`PPP_SIDE_W-1:0]  side_dir,
  input  wire logic [`PPP_SIDE_W-1:0]  side_out,
  input  wire logic                    ack_irq_enable,
  input  wire logic                    accept_req,
  // Host transmit stream
  input  wire logic                    tx_valid,
  output logic                         tx_ready,
  input  wire logic [`PPP_DATA_W-1:0]  tx_data,
  // Host receive stream
  output logic                         rx_valid,
  input  wire logic                    rx_ready,
  output logic [`PPP_DATA_W-1:0]       rx_data,
  // Status and interrupt
  output logic                         ack_irq,
  output logic [`PPP_SIDE_W-1:0]       side_in,
  output logic                         rx_pending,
  output logic                         system_reset_n,
  // Data pins
  input  wire logic [`PPP_DATA_W-1:0]  adapter_port_a_lines_in,
  output logic [`PPP_DATA_W-1:0]       adapter_port_a_lines_out,
  output logic [`PPP_DATA_W-1:0]       adapter_port_a_lines_oe_n,
  // Handshake pins
  output logic                         host_data_ready_n,
  input  wire logic                    ack_n_in,
  // Side pins: busy/serial data, paper_out_line/serial clock, select/ring
  input  wire logic [`PPP_SIDE_W-1:0]  side_lines_in,
  output logic [`PPP_SIDE_W-1:0]       side_lines_out,
  output logic [`PPP_SIDE_W-1:0]       side_lines_oe_n
);
  import ppp_pkg::*;

  ppp_state_type                state;
  ppp_state_type                next_state;
  logic [`PPP_CNT_W-1:0]        cnt;
  logic [`PPP_CNT_W-1:0]        next_cnt;
  logic [`PPP_DATA_W-1:0]       out_byte;
  logic [`PPP_DATA_W-1:0]       next_out_byte;
  logic                         strobe_n;
  logic                         next_strobe_n;
  logic                         next_tx_ready;
  logic                         ack_seen;
  logic                         next_ack_seen;
  logic                         rx_push;
  logic                         buf_in_ready;
  logic                         buf_out_valid;
  logic [`PPP_DATA_W-1:0]       buf_out_data;
  logic [`PPP_DATA_W-1:0]       data_s1;
  logic [`PPP_DATA_W-1:0]       data_s2;
  logic [`PPP_SIDE_W-1:0]       side_s1;
  logic [`PPP_SIDE_W-1:0]       side_s2;
  logic                         ack_s1;
  logic                         ack_s2;
  logic                         ack_prev;
  logic                         ack_fall;
  logic                         next_irq;
  logic [`PPP_DATA_W-1:0]       next_data_oe_n;
  logic [`PPP_SIDE_W-1:0]       next_side_oe_n;
  logic                         hold_valid;
  logic [`PPP_DATA_W-1:0]       hold_data;
  logic                         next_hold_valid;
  logic [`PPP_DATA_W-1:0]       next_hold_data;

  // Pin synchronisers, two flops each
  always_ff @(posedge core_clk) begin
    if (rst) begin
      data_s1  <= `PPP_DIR_RESET;
      data_s2  <= `PPP_DIR_RESET;
      side_s1  <= `PPP_SIDE_RESET;
      side_s2  <= `PPP_SIDE_RESET;
      ack_s1   <= 1'b1;
      ack_s2   <= 1'b1;
      ack_prev <= 1'b1;
    end else begin
      data_s1  <= adapter_port_a_lines_in;
      data_s2  <= data_s1;
      side_s1  <= side_lines_in;
      side_s2  <= side_s1;
      ack_s1   <= ack_n_in;
      ack_s2   <= ack_s1;
      ack_prev <= ack_s2;
    end
  end

  // Acknowledge going active, used in both modes
  assign ack_fall = ack_prev && !ack_s2;
  assign next_irq = ack_irq_enable && ack_fall;

  // Per-bit direction: a set bit drives its pin, except that input mode releases every data pin
  always_comb begin
    next_data_oe_n = ~data_dir;
    next_side_oe_n = ~side_dir;
    if (input_mode) begin
      next_data_oe_n = {`PPP_DATA_W{1'b1}};
    end
  end

  // Handshake sequencer; ready is registered, so a byte it promised is always taken
  always_comb begin
    next_state    = state;
    next_cnt      = cnt;
    next_out_byte = out_byte;
    next_strobe_n = 1'b1;
    next_tx_ready = 1'b0;
    next_ack_seen = ack_seen;
    rx_push       = 1'b0;
    case (state)
      ppp_idle_type_s: begin
        next_ack_seen = 1'b0;
        if (tx_ready && tx_valid) begin
          next_out_byte = tx_data;
          next_state    = ppp_setup_type_s;
          next_cnt      = `PPP_CNT_W'(SETUP_CYC - 1);
        end else if (input_mode) begin
          // Accept when peripheral ready and buffer has room
          if (ack_fall && buf_in_ready) begin
            rx_push = 1'b1;
          end
          if (accept_req) begin
            next_state    = ppp_iack_type_s;
            next_cnt      = `PPP_CNT_W'(STROBE_CYC - 1);
            next_strobe_n = 1'b0;
          end
        end else begin
          next_tx_ready = 1'b1;
        end
      end
      ppp_setup_type_s: begin
        // Data stands before the strobe
        if (cnt == '0) begin
          next_state    = ppp_strobe_type_s;
          next_cnt      = `PPP_CNT_W'(STROBE_CYC - 1);
          next_strobe_n = 1'b0;
        end else begin
          next_cnt = cnt - `PPP_CNT_W'(1);
        end
      end
      ppp_strobe_type_s: begin
        // An answer inside the strobe is legal and must not be lost
        if (ack_fall) begin
          next_ack_seen = 1'b1;
        end
        if (cnt == '0) begin
          next_state = ppp_wait_type_s;
        end else begin
          next_strobe_n = 1'b0;
          next_cnt      = cnt - `PPP_CNT_W'(1);
        end
      end
      ppp_wait_type_s: begin
        // Peripheral may answer at any time, no upper bound
        if (ack_seen || ack_fall || !ack_s2) begin
          next_state = ppp_idle_type_s;
        end
      end
      ppp_iack_type_s: begin
        if (cnt == '0) begin
          next_state = ppp_idle_type_s;
        end else begin
          next_strobe_n = 1'b0;
          next_cnt      = cnt - `PPP_CNT_W'(1);
        end
      end
      default: begin
        next_state = ppp_idle_type_s;
      end
    endcase
  end

  // Output register for receive stream
  always_comb begin
    next_hold_valid = hold_valid;
    next_hold_data  = hold_data;
    if (!hold_valid || rx_ready) begin
      next_hold_valid = buf_out_valid;
      next_hold_data  = buf_out_data;
    end
  end

  // Register all state and pin drives
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state                     <= ppp_idle_type_s;
      cnt                       <= '0;
      out_byte                  <= `PPP_DIR_RESET;
      strobe_n                  <= 1'b1;
      tx_ready                  <= 1'b0;
      ack_seen                  <= 1'b0;
      rx_pending                <= 1'b0;
      hold_valid                <= 1'b0;
      hold_data                 <= `PPP_DIR_RESET;
      ack_irq                   <= 1'b0;
      adapter_port_a_lines_oe_n <= {`PPP_DATA_W{1'b1}};
      side_lines_oe_n           <= {`PPP_SIDE_W{1'b1}};
      side_lines_out            <= `PPP_SIDE_RESET;
      side_in                   <= `PPP_SIDE_RESET;
      system_reset_n            <= 1'b0;
    end else begin
      state                     <= next_state;
      cnt                       <= next_cnt;
      out_byte                  <= next_out_byte;
      strobe_n                  <= next_strobe_n;
      tx_ready                  <= next_tx_ready;
      ack_seen                  <= next_ack_seen;
      rx_pending                <= buf_out_valid; // Status lags the buffer by a cycle
      hold_valid                <= next_hold_valid;
      hold_data                 <= next_hold_data;
      ack_irq                   <= next_irq;
      adapter_port_a_lines_oe_n <= next_data_oe_n;
      side_lines_oe_n           <= next_side_oe_n;
      side_lines_out            <= side_out;
      side_in                   <= side_s2;
      system_reset_n            <= 1'b1;
    end
  end

  assign host_data_ready_n        = strobe_n;
  assign adapter_port_a_lines_out = out_byte;
  assign rx_valid                 = hold_valid;
  assign rx_data                  = hold_data;

  // Receive buffer; a stalled reader loses no byte until three are held, then further bytes are dropped
  ppp_skid #(
    .WIDTH (`PPP_DATA_W)
  ) u_rx_buf (
    .core_clk  (core_clk),
    .rst       (rst),
    .in_valid  (rx_push),
    .in_ready  (buf_in_ready),
    .in_data   (data_s2),
    .out_valid (buf_out_valid),
    .out_ready (!hold_valid || rx_ready),
    .out_data  (buf_out_data)
  );
endmodule
`default_nettype wire

// ===== testbench/ppp_port_assertions.sv
// Checker for the parallel port handshake engine
// Assumes it is bound onto ppp_port and sees its ports only
`timescale 1ns/1ps
`default_nettype none
module ppp_port_checker #(
  parameter int SETUP_CYC  = 2,
  parameter int STROBE_CYC = 2
) (
  // Clock, reset and control
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic       input_mode,
  input wire logic [7:0] data_dir,
  input wire logic [2:0] side_dir,
  input wire logic       ack_irq_enable,
  // Streams and status
  input wire logic       tx_valid,
  input wire logic       tx_ready,
  input wire logic       rx_valid,
  input wire logic       rx_ready,
  input wire logic [7:0] rx_data,
  input wire logic       ack_irq,
  input wire logic       system_reset_n,
  // Pins
  input wire logic [7:0] adapter_port_a_lines_out,
  input wire logic [7:0] adapter_port_a_lines_oe_n,
  input wire logic       host_data_ready_n,
  input wire logic       ack_n_in,
  input wire logic [2:0] side_lines_oe_n
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  int setup_cnt;
  int low_cnt;
  // Cycles since a byte was taken, cycles of strobe low
  always_ff @(posedge core_clk) begin
    setup_cnt <= (tx_valid && tx_ready) ? 0 : setup_cnt + 1;
    low_cnt   <= host_data_ready_n ? 0 : low_cnt + 1;
  end
  sequence ack_fall_s;
    $fell(ack_n_in) && ack_irq_enable;
  endsequence
  sequence rx_room_s;
    $fell(ack_n_in) && input_mode && !rx_valid;
  endsequence
  reset_quiet_a: assert property (disable iff (1'b0) rst |=> &adapter_port_a_lines_oe_n && host_data_ready_n
    && !ack_irq && !rx_valid && !system_reset_n) else $error("outputs not quiet in reset");
  setup_time_a: assert property ($fell(host_data_ready_n) && !input_mode |->
    setup_cnt inside {[SETUP_CYC:SETUP_CYC+1]}) else $error("data setup before strobe wrong");
  strobe_width_a: assert property ($rose(host_data_ready_n) |-> low_cnt == STROBE_CYC)
    else $error("strobe width wrong");
  data_hold_a: assert property (!host_data_ready_n && !input_mode |-> $stable(adapter_port_a_lines_out))
    else $error("data moved under strobe");
  busy_refuse_a: assert property (!host_data_ready_n || $past(input_mode) |-> !tx_ready)
    else $error("byte offered while busy");
  pins_release_a: assert property (input_mode [*3] |-> &adapter_port_a_lines_oe_n)
    else $error("data pins driven in input mode");
  data_dir_a: assert property ((!input_mode && $stable(data_dir)) [*3] |->
    adapter_port_a_lines_oe_n == ~data_dir) else $error("data direction wrong");
  side_dir_a: assert property ($stable(side_dir) [*3] |-> side_lines_oe_n == ~side_dir)
    else $error("side direction wrong");
  irq_raise_a: assert property (ack_fall_s |-> ##[1:5] ack_irq) else $error("no interrupt on ack");
  irq_pulse_a: assert property (ack_irq |-> ack_irq_enable ##1 !ack_irq)
    else $error("interrupt not a gated pulse");
  rx_push_a: assert property (rx_room_s |-> ##[1:6] rx_valid) else $error("input byte not offered");
  rx_hold_a: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
    else $error("received byte lost in stall");
endmodule
bind ppp_port ppp_port_checker #(.SETUP_CYC(SETUP_CYC), .STROBE_CYC(STROBE_CYC)) i_chk (.core_clk, .rst,
  .input_mode, .data_dir, .side_dir, .ack_irq_enable, .tx_valid, .tx_ready, .rx_valid, .rx_ready, .rx_data,
  .ack_irq, .system_reset_n, .adapter_port_a_lines_out, .adapter_port_a_lines_oe_n, .host_data_ready_n,
  .ack_n_in, .side_lines_oe_n);
`default_nettype wire

// ===== testbench/ppp_printer_model.sv
// Behavioural parallel peripheral facing the port pins
// Assumes the bench resolves shared data pins
`timescale 1ns/1ps
`default_nettype none
module ppp_printer_model (
  // Clock and mode
  input  wire logic       core_clk,
  input  wire logic       input_mode,
  // Pins toward the port
  input  wire logic       host_data_ready_n,
  input  wire logic [7:0] data_pins,
  output logic            ack_n,
  output logic [7:0]      data_drv,
  // Last byte latched
  output logic [7:0]      got_byte
);
  int ack_delay = 0;
  initial begin
    ack_n    = 1'b1;
    data_drv = 8'h5a;
    got_byte = 8'h00;
  end
  // Acknowledge pulse, long enough to pass a synchroniser
  task automatic pulse_ack();
    @(negedge core_clk);
    ack_n = 1'b0;
    repeat (3) @(negedge core_clk);
    ack_n = 1'b1;
  endtask
  // Output cycle: latch on strobe, answer after a set delay
  always @(negedge host_data_ready_n) begin
    if (!input_mode) begin
      got_byte = data_pins;
      repeat (ack_delay) @(negedge core_clk);
      pulse_ack();
    end
  end
  // Input cycle: data first, then ready, then let data wander
  task automatic send_byte(input logic [7:0] b);
    @(negedge core_clk);
    data_drv = b;
    pulse_ack();
    repeat (3) @(negedge core_clk);
    data_drv = ~b;
  endtask
endmodule
`default_nettype wire

// ===== testbench/parallel_printer_port_handshake_bench.sv
// Self-checking bench for the parallel port handshake engine
// Assumes the printer model and bound checker are compiled
`timescale 1ns/1ps
`default_nettype none
module parallel_printer_port_handshake_bench;
  import ppp_pkg::*;
  localparam int STROBE = 3;
  logic core_clk = 1'b0, rst = 1'b1, input_mode = 1'b0, ack_irq_enable = 1'b0, accept_req = 1'b0;
  logic tx_valid = 1'b0, rx_ready = 1'b0, tx_ready, rx_valid, ack_irq, rx_pending, system_reset_n;
  logic host_data_ready_n, ack_n, rx_pend;
  logic [7:0] data_dir = 8'h00, tx_data = 8'h00, rx_data, d_out, d_oe_n, prn_data, got, d_wire;
  logic [2:0] side_dir = 3'h0, side_out = 3'h0, side_far = 3'h0, side_in, s_out, s_oe_n, s_wire;
  int n_mismatch = 0, cmp_count = 0, irq_seen = 0, i;
  // Shared pins: whoever enables drives
  assign d_wire = (~d_oe_n & d_out) | (d_oe_n & prn_data);
  assign s_wire = (~s_oe_n & s_out) | (s_oe_n & side_far);
  always #25 core_clk = ~core_clk;
  always @(posedge core_clk) if (ack_irq === 1'b1) irq_seen++;
  ppp_port #(.SETUP_CYC(4), .STROBE_CYC(STROBE)) i_dut (.core_clk, .rst, .input_mode, .data_dir, .side_dir,
    .side_out, .ack_irq_enable, .accept_req, .tx_valid, .tx_ready, .tx_data, .rx_valid, .rx_ready, .rx_data,
    .ack_irq, .side_in, .rx_pending(rx_pend), .system_reset_n, .adapter_port_a_lines_in(d_wire),
    .adapter_port_a_lines_out(d_out), .adapter_port_a_lines_oe_n(d_oe_n), .host_data_ready_n,
    .ack_n_in(ack_n), .side_lines_in(s_wire), .side_lines_out(s_out), .side_lines_oe_n(s_oe_n));
  ppp_printer_model i_prn (.core_clk, .input_mode, .host_data_ready_n, .data_pins(d_wire), .ack_n,
    .data_drv(prn_data), .got_byte(got));
  // Compare and count
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wait_strobe(input logic lvl);
    for (i = 0; i < 300 && host_data_ready_n !== lvl; i++) @(negedge core_clk);
    check("strobe level", {7'h0, lvl}, {7'h0, host_data_ready_n});
  endtask
  // Offer one byte, see it on the pins under the strobe
  task automatic out_byte(input logic [7:0] b);
    tx_data = b;
    tx_valid = 1'b1;
    for (i = 0; i < 300 && tx_ready !== 1'b1; i++) @(negedge core_clk);
    check("ready offered", 8'h01, {7'h0, tx_ready});
    @(negedge core_clk);
    tx_valid = 1'b0;
    wait_strobe(1'b0);
    check("pins under strobe", b, d_wire);
    wait_strobe(1'b1);
  endtask
  task automatic test_output();
    ack_irq_enable = 1'b1;
    data_dir = 8'hff;
    i_prn.ack_delay = 6;
    out_byte(8'ha5);
    tx_data = 8'h3c;
    tx_valid = 1'b1;
    check("ready before ack", 8'h00, {7'h0, tx_ready});
    check("printer byte", 8'ha5, got);
    i_prn.ack_delay = 0;
    @(negedge core_clk);
    out_byte(8'h3c);
    check("printer byte", 8'h3c, got);
    repeat (10) @(negedge core_clk);
    check("ack interrupts", 8'h02, irq_seen[7:0]);
  endtask
  // Three bytes in while the reader stalls, then drain
  task automatic test_input();
    logic [7:0] exp[3] = '{8'h81, 8'h7e, 8'h00};
    ack_irq_enable = 1'b0;
    input_mode = 1'b1;
    repeat (4) @(negedge core_clk);
    check("pins released", 8'hff, d_oe_n);
    foreach (exp[k]) i_prn.send_byte(exp[k]);
    check("pending in buffer", 8'h01, {7'h0, rx_pend});
    foreach (exp[k]) begin
      for (i = 0; i < 20 && rx_valid !== 1'b1; i++) @(negedge core_clk);
      check("receive valid", 8'h01, {7'h0, rx_valid});
      check("received byte", exp[k], rx_data);
      rx_ready = 1'b1;
      @(negedge core_clk);
      rx_ready = 1'b0;
      @(negedge core_clk);
    end
    check("buffer drained", 8'h00, {7'h0, rx_pend});
    check("masked interrupt", 8'h02, irq_seen[7:0]);
  endtask
  // Accept pulse from the host in input mode
  task automatic test_accept();
    int n = 0;
    accept_req = 1'b1;
    @(negedge core_clk);
    accept_req = 1'b0;
    wait_strobe(1'b0);
    while (host_data_ready_n === 1'b0 && n < 100) begin
      n++;
      @(negedge core_clk);
    end
    check("accept width", 8'(STROBE), n[7:0]);
  endtask
  // Side lines: two driven, select read from the far side
  task automatic test_side();
    input_mode = 1'b0;
    data_dir = 8'h3c;
    side_dir = 3'b011;
    side_out = 3'b101;
    side_far = 3'b110;
    repeat (5) @(negedge core_clk);
    check("data enables", 8'hc3, d_oe_n);
    check("side enables", 8'h04, {5'h0, s_oe_n});
    check("side sampled", 8'h05, {5'h0, side_in});
    side_dir = 3'b000;
    repeat (5) @(negedge core_clk);
    check("side inputs", 8'h06, {5'h0, side_in});
    check("reset out high", 8'h01, {7'h0, system_reset_n});
  endtask
  task automatic complete_run();
    if (n_mismatch == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (2) @(negedge core_clk);
    check("reset pins", 8'hff, d_oe_n);
    check("reset out", 8'h00, {7'h0, system_reset_n});
    rst = 1'b0;
    test_output();
    test_input();
    test_accept();
    test_side();
    complete_run();
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    n_mismatch++;
    complete_run();
  end
endmodule
`default_nettype wire
